// file: dicl_cache.sv
// Purpose: Instruction cache lookup, line fill, flush and RAM-set preload.
// Assumes: Core and external memory port run on core_clk.
// Notes: The core status word three is held here for its cache bits.
// Summary of operation
// - Fill stores address bits 23..13 as tag.
// - Bits 12..4 select one of 512 sets.
// - Bits 3..2 pick the word in line.
// - Byte bits 1..0 never take part.
// - RAM set compares bits 23..12 with tag.
// - Bits 11..4 select one of 256 lines.
// - Hit needs tag match and valid line.
// - Total miss fills a 2-way line.
// - RAM-set tag match, invalid line: fill it.
// - RAM-set hit wins, no 2-way allocation.
// - 2-way hit alone answers without external access.
// - Fill fetches aligned four-word block, word-wise.
// - Requested word forwarded as soon as written.
// - Tag and valid written after all words.
// - Disabled cache passes fetches straight through.
// - Reset clears enable and flush bits.
// - Flush clears all line and tag valids.
// - Flush bit reads one until flush ends.
// - Frozen cache serves hits, misses leave arrays.
// - Allocation replaces LRU way, one bit/set.
// - Enabled flag rises some cycles after enable.
// - Tag write while enabled reloads whole RAM set, then valid.
module dicl_cache
    import dicl_pkg::*;
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic fetch_req,
    input wire logic [ADDR_W-1:0] fetch_addr,
    output logic fetch_ready,
    output logic fetch_rvalid,
    output logic [DATA_W-1:0] fetch_rdata,
    input wire logic st_wr,
    input wire logic [ST_W-1:0] st_wdata,
    output logic [ST_W-1:0] st_rdata,
    output logic cache_enabled,
    input wire logic [NUM_RS-1:0] rs_tag_wr,
    input wire logic [RS_TAG_W-1:0] rs_tag_wdata,
    output logic [NUM_RS-1:0] rs_tag_valid,
    output logic mem_req_valid,
    output dicl_mreq_t mem_req,
    input wire logic mem_req_ready,
    input wire logic mem_rvalid,
    input wire logic [DATA_W-1:0] mem_rdata
);
    // Control state and its next values.
    dicl_state_t state_q, state_d;
    dicl_kind_t kind_q, kind_d;
    logic [ADDR_W-1:0] addr_q, addr_d; // Address of the request in service.
    logic tgt_q, tgt_d; // Way or RAM set being filled.
    logic [OFF_W-1:0] beat_q, beat_d; // Word number of the next fill beat.
    logic [RS_IDX_W-1:0] line_q, line_d; // Preload line counter.
    logic pre_q, pre_d; // A RAM-set preload is running.
    logic [WAY_IDX_W-1:0] fidx_q, fidx_d; // Flush sweep position.
    logic rvalid_q, rvalid_d;
    logic [DATA_W-1:0] rdata_q, rdata_d;
    dicl_mreq_t mreq_q, mreq_d;
    logic [(1<<WAY_IDX_W)-1:0] lru_q, lru_d; // Way to replace next, per set.
    logic [NUM_WAYS-1:0][(1<<WAY_IDX_W)-1:0] way_lv_q, way_lv_d;
    logic [NUM_RS-1:0][(1<<RS_IDX_W)-1:0] rs_lv_q, rs_lv_d;
    logic [NUM_RS-1:0] rs_tv_q, rs_tv_d;
    logic [NUM_RS-1:0][RS_TAG_W-1:0] rs_tag_q, rs_tag_d;
    logic [NUM_RS-1:0] rs_pend_q, rs_pend_d; // Preload waiting to start.
    logic flush_done; // Last cycle of the flush sweep.
    // Status word and enable delay counter.
    logic [ST_W-1:0] st_q, st_d;
    logic [3:0] en_cnt_q, en_cnt_d;

    // Address fields of the incoming fetch and of the held request.
    logic [WAY_IDX_W-1:0] rd_way_idx, q_way_idx;
    logic [RS_IDX_W-1:0] rd_rs_idx, q_rs_idx, wr_rs_idx;
    logic [OFF_W-1:0] rd_off, q_off;
    assign rd_way_idx = fetch_addr[WAY_IDX_HI:IDX_LO];
    assign q_way_idx = addr_q[WAY_IDX_HI:IDX_LO];
    assign rd_rs_idx = fetch_addr[RS_IDX_HI:IDX_LO];
    assign q_rs_idx = addr_q[RS_IDX_HI:IDX_LO];
    assign rd_off = fetch_addr[OFF_HI:OFF_LO];
    assign q_off = addr_q[OFF_HI:OFF_LO];
    assign wr_rs_idx = pre_q ? line_q : q_rs_idx;

    // Array ports.
    logic [NUM_WAYS-1:0] way_we, way_tag_we, way_lv_at, way_match, way_hit;
    logic [NUM_WAYS-1:0][DATA_W-1:0] way_rd;
    logic [NUM_WAYS-1:0][WAY_TAG_W-1:0] way_tag_rd;
    logic [NUM_RS-1:0] rs_we, rs_lv_at, rs_match, rs_hit;
    logic [NUM_RS-1:0][DATA_W-1:0] rs_rd;

    // The 2-way data and tag arrays; a fill writes, otherwise the fetch reads.
    for (genvar w = 0; w < NUM_WAYS; w++) begin : g_way
        assign way_we[w] = (state_q == S_MDATA) && mem_rvalid && (kind_q == K_WAY)
                           && (tgt_q == 1'(w));
        assign way_tag_we[w] = (state_q == S_FIN) && (kind_q == K_WAY)
                               && (tgt_q == 1'(w));
        assign way_lv_at[w] = way_lv_q[w][q_way_idx];
        dicl_mem #(.WIDTH(DATA_W), .DEPTH(1 << (WAY_IDX_W + OFF_W))) u_data (
            .core_clk(core_clk),
            .we(way_we[w]),
            .addr(way_we[w] ? {q_way_idx, beat_q} : {rd_way_idx, rd_off}),
            .wdata(mem_rdata),
            .rdata(way_rd[w])
        );
        dicl_mem #(.WIDTH(WAY_TAG_W), .DEPTH(1 << WAY_IDX_W)) u_tag (
            .core_clk(core_clk),
            .we(way_tag_we[w]),
            .addr(way_tag_we[w] ? q_way_idx : rd_way_idx),
            .wdata(addr_q[WAY_TAG_HI:WAY_TAG_LO]),
            .rdata(way_tag_rd[w])
        );
    end

    // The RAM-set data arrays; their tags sit in registers.
    for (genvar k = 0; k < NUM_RS; k++) begin : g_rs
        assign rs_we[k] = (state_q == S_MDATA) && mem_rvalid && (kind_q == K_RS)
                          && (tgt_q == 1'(k));
        assign rs_lv_at[k] = rs_lv_q[k][q_rs_idx];
        dicl_mem #(.WIDTH(DATA_W), .DEPTH(1 << (RS_IDX_W + OFF_W))) u_data (
            .core_clk(core_clk),
            .we(rs_we[k]),
            .addr(rs_we[k] ? {wr_rs_idx, beat_q} : {rd_rs_idx, rd_off}),
            .wdata(mem_rdata),
            .rdata(rs_rd[k])
        );
    end

    // Tag compares; both ways of the set are checked at once.
    dicl_hit_check #(.N(NUM_WAYS), .TW(WAY_TAG_W)) u_way_chk (
        .tags(way_tag_rd),
        .want(addr_q[WAY_TAG_HI:WAY_TAG_LO]),
        .tag_ok({NUM_WAYS{1'b1}}),
        .line_ok(way_lv_at),
        .match(way_match),
        .hit(way_hit)
    );
    // A RAM-set tag only counts while its tag-valid bit is set.
    dicl_hit_check #(.N(NUM_RS), .TW(RS_TAG_W)) u_rs_chk (
        .tags(rs_tag_q),
        .want(addr_q[WAY_TAG_HI:RS_TAG_LO]),
        .tag_ok(rs_tv_q),
        .line_ok(rs_lv_at),
        .match(rs_match),
        .hit(rs_hit)
    );

    // Lowest numbered candidate of each kind.
    logic way_sel, rs_hit_sel, rs_match_sel, pend_sel;
    logic [DATA_W-1:0] rs_word;
    always_comb begin
        way_sel = 1'b0;
        rs_hit_sel = 1'b0;
        rs_match_sel = 1'b0;
        pend_sel = 1'b0;
        for (int i = NUM_RS - 1; i >= 0; i--) begin
            if (rs_hit[i]) begin
                rs_hit_sel = 1'(i);
            end
            if (rs_match[i]) begin
                rs_match_sel = 1'(i);
            end
            if (rs_pend_q[i]) begin
                pend_sel = 1'(i);
            end
        end
        for (int i = NUM_WAYS - 1; i >= 0; i--) begin
            if (way_hit[i]) begin
                way_sel = 1'(i);
            end
        end
        rs_word = rs_rd[rs_hit_sel];
    end

    // Requests are held off during a flush or before a pending preload.
    assign fetch_ready = (state_q == S_IDLE) && !st_q[ST_FLUSH_BIT]
                         && !(cache_enabled && |rs_pend_q);

    // Next values of the controller, the valid bits and the LRU bits.
    always_comb begin
        state_d = state_q;
        kind_d = kind_q;
        addr_d = addr_q;
        tgt_d = tgt_q;
        beat_d = beat_q;
        line_d = line_q;
        pre_d = pre_q;
        fidx_d = fidx_q;
        rvalid_d = 1'b0;
        rdata_d = rdata_q;
        mreq_d = mreq_q;
        lru_d = lru_q;
        way_lv_d = way_lv_q;
        rs_lv_d = rs_lv_q;
        rs_tv_d = rs_tv_q;
        rs_tag_d = rs_tag_q;
        rs_pend_d = rs_pend_q;
        flush_done = 1'b0;
        case (state_q)
            S_IDLE: begin
                if (st_q[ST_FLUSH_BIT]) begin
                    // Flush has priority over preloads and fetches.
                    state_d = S_FLUSH;
                    fidx_d = '0;
                    rs_tv_d = '0;
                end else if (cache_enabled && |rs_pend_q) begin
                    pre_d = 1'b1;
                    tgt_d = pend_sel;
                    kind_d = K_RS;
                    line_d = '0;
                    beat_d = '0;
                    rs_pend_d[pend_sel] = 1'b0;
                    mreq_d = '{addr: {rs_tag_q[pend_sel], 8'h00, 4'h0}, burst: 1'b1};
                    state_d = S_MREQ;
                end else if (fetch_req) begin
                    addr_d = fetch_addr;
                    beat_d = '0;
                    if (cache_enabled) begin
                        state_d = S_LOOK;
                    end else begin
                        // Single-word pass-through, arrays untouched.
                        kind_d = K_BYP;
                        mreq_d = '{addr: {fetch_addr[ADDR_W-1:2], 2'b00}, burst: 1'b0};
                        state_d = S_MREQ;
                    end
                end
            end
            S_LOOK: begin
                mreq_d = '{addr: {addr_q[ADDR_W-1:IDX_LO], 4'h0}, burst: 1'b1};
                if (|rs_hit) begin
                    rvalid_d = 1'b1;
                    rdata_d = rs_word;
                    state_d = S_IDLE;
                end else if (|rs_match) begin
                    kind_d = st_q[ST_FRZ_BIT] ? K_DROP : K_RS;
                    tgt_d = rs_match_sel;
                    state_d = S_MREQ;
                end else if (|way_hit) begin
                    rvalid_d = 1'b1;
                    rdata_d = way_rd[way_sel];
                    lru_d[q_way_idx] = ~way_sel;
                    state_d = S_IDLE;
                end else begin
                    kind_d = st_q[ST_FRZ_BIT] ? K_DROP : K_WAY;
                    tgt_d = lru_q[q_way_idx];
                    state_d = S_MREQ;
                end
            end
            S_MREQ: begin
                if (mem_req_ready) begin
                    state_d = S_MDATA;
                end
            end
            S_MDATA: begin
                if (mem_rvalid) begin
                    beat_d = beat_q + 2'h1;
                    // The wanted word goes out in the cycle after its beat is written.
                    if (!pre_q && (kind_q == K_BYP || beat_q == q_off)) begin
                        rvalid_d = 1'b1;
                        rdata_d = mem_rdata;
                    end
                    if (kind_q == K_BYP) begin
                        state_d = S_IDLE;
                    end else if (beat_q == LAST_BEAT) begin
                        state_d = S_FIN;
                    end
                end
            end
            S_FIN: begin
                // Line completed; validate only now, never after a frozen miss.
                if (kind_q == K_WAY) begin
                    way_lv_d[tgt_q][q_way_idx] = 1'b1;
                    lru_d[q_way_idx] = ~tgt_q;
                end else if (kind_q == K_RS) begin
                    rs_lv_d[tgt_q][wr_rs_idx] = 1'b1;
                end
                state_d = S_IDLE;
                if (pre_q) begin
                    if (line_q == LAST_LINE) begin
                        rs_tv_d[tgt_q] = 1'b1;
                        pre_d = 1'b0;
                    end else begin
                        line_d = line_q + 8'h01;
                        mreq_d.addr = {rs_tag_q[tgt_q], line_q + 8'h01, 4'h0};
                        state_d = S_MREQ;
                    end
                end
            end
            S_FLUSH: begin
                // One set per cycle; RAM-set lines are covered twice.
                for (int w = 0; w < NUM_WAYS; w++) begin
                    way_lv_d[w][fidx_q] = 1'b0;
                end
                for (int k = 0; k < NUM_RS; k++) begin
                    rs_lv_d[k][fidx_q[RS_IDX_W-1:0]] = 1'b0;
                end
                fidx_d = fidx_q + 9'h001;
                if (fidx_q == LAST_SET) begin
                    flush_done = 1'b1;
                    state_d = S_IDLE;
                end
            end
            default: begin
                state_d = S_IDLE;
            end
        endcase
        // A tag write drops tag-valid and, when enabled, queues a reload; it beats a start.
        for (int k = 0; k < NUM_RS; k++) begin
            if (rs_tag_wr[k]) begin
                rs_tag_d[k] = rs_tag_wdata;
                rs_tv_d[k] = 1'b0;
                rs_pend_d[k] = cache_enabled;
            end
        end
    end

    // Registers of the controller.
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= S_IDLE;
            kind_q <= K_BYP;
            addr_q <= '0;
            tgt_q <= 1'b0;
            beat_q <= '0;
            line_q <= '0;
            pre_q <= 1'b0;
            fidx_q <= '0;
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            mreq_q <= '0;
            lru_q <= '0;
            way_lv_q <= '0;
            rs_lv_q <= '0;
            rs_tv_q <= '0;
            rs_tag_q <= '0;
            rs_pend_q <= '0;
        end else begin
            state_q <= state_d;
            kind_q <= kind_d;
            addr_q <= addr_d;
            tgt_q <= tgt_d;
            beat_q <= beat_d;
            line_q <= line_d;
            pre_q <= pre_d;
            fidx_q <= fidx_d;
            rvalid_q <= rvalid_d;
            rdata_q <= rdata_d;
            mreq_q <= mreq_d;
            lru_q <= lru_d;
            way_lv_q <= way_lv_d;
            rs_lv_q <= rs_lv_d;
            rs_tv_q <= rs_tv_d;
            rs_tag_q <= rs_tag_d;
            rs_pend_q <= rs_pend_d;
        end
    end

    // Status word: a software set of the flush bit wins over its own end.
    always_comb begin
        st_d = st_q;
        if (st_wr) begin
            st_d = st_wdata;
        end
        st_d[ST_RO_BIT] = 1'b0;
        st_d[ST_FLUSH_BIT] = (st_q[ST_FLUSH_BIT] && !flush_done)
                             || (st_wr && st_wdata[ST_FLUSH_BIT]);
        if (!st_q[ST_EN_BIT]) begin
            en_cnt_d = 4'h0;
        end else if (en_cnt_q == ENABLE_CNT) begin
            en_cnt_d = en_cnt_q;
        end else begin
            en_cnt_d = en_cnt_q + 4'h1;
        end
    end

    // Registers of the status word.
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_q <= ST_RESET;
            en_cnt_q <= 4'h0;
        end else begin
            st_q <= st_d;
            en_cnt_q <= en_cnt_d;
        end
    end

    assign cache_enabled = (en_cnt_q == ENABLE_CNT);
    assign st_rdata = st_q;
    assign rs_tag_valid = rs_tv_q;
    assign fetch_rvalid = rvalid_q;
    assign fetch_rdata = rdata_q;
    assign mem_req_valid = (state_q == S_MREQ);
    assign mem_req = mreq_q;

    // Checks kept beside the logic.
    a_flush_bit_busy: assert property (@(posedge core_clk) disable iff (sys_rst)
        state_q == S_FLUSH |-> st_rdata[ST_FLUSH_BIT]) else $error("flush bit low mid flush");
    a_flush_end_sweep: assert property (@(posedge core_clk) disable iff (sys_rst)
        $fell(st_rdata[ST_FLUSH_BIT]) |-> $past(fidx_q) == LAST_SET && rs_tv_q == '0)
        else $error("flush ended early");
    a_disabled_pass: assert property (@(posedge core_clk) disable iff (sys_rst)
        fetch_req && fetch_ready && !cache_enabled |=> mem_req_valid && !mem_req.burst)
        else $error("disabled fetch not passed on");
    a_fill_block_aligned: assert property (@(posedge core_clk) disable iff (sys_rst)
        mem_req_valid && mem_req.burst |-> mem_req.addr[3:0] == 4'h0)
        else $error("fill block not aligned");
    a_valid_after_line: assert property (@(posedge core_clk) disable iff (sys_rst)
        state_q == S_FIN |-> $past(state_q) == S_MDATA && $past(beat_q) == LAST_BEAT)
        else $error("line validated before last word");
    a_freeze_no_write: assert property (@(posedge core_clk) disable iff (sys_rst)
        state_q == S_LOOK && st_q[ST_FRZ_BIT] |=> state_q == S_IDLE || kind_q == K_DROP)
        else $error("frozen miss would write an array");
    a_rs_hit_wins: assert property (@(posedge core_clk) disable iff (sys_rst)
        state_q == S_LOOK && |rs_hit |=> fetch_rvalid && fetch_rdata == $past(rs_word)
        && state_q == S_IDLE) else $error("RAM-set hit not served");
    a_way_hit_direct: assert property (@(posedge core_clk) disable iff (sys_rst)
        state_q == S_LOOK && |way_hit && !(|rs_match) |=> fetch_rvalid && !mem_req_valid)
        else $error("2-way hit went external");
    a_early_word: assert property (@(posedge core_clk) disable iff (sys_rst)
        state_q == S_MDATA && mem_rvalid && !pre_q && kind_q != K_BYP && beat_q == q_off
        |=> fetch_rvalid && fetch_rdata == $past(mem_rdata)) else $error("word not forwarded");
    a_enable_delay: assert property (@(posedge core_clk) disable iff (sys_rst)
        $rose(st_q[ST_EN_BIT]) |-> !cache_enabled [*4] ##1 cache_enabled)
        else $error("enabled flag timing wrong");
endmodule

// file: dicl_pkg.sv
// Purpose: Shared constants and types for the instruction cache lookup block.
// Assumes: 24-bit byte fetch addresses and 32-bit instruction words.
// Notes: Address field positions, the status word reset value and the enable delay count live here.
package dicl_pkg;
    // Address and data widths.
    localparam int ADDR_W = 24;
    localparam int DATA_W = 32;
    // Array geometry.
    localparam int NUM_WAYS = 2;
    localparam int NUM_RS = 2;
    localparam int OFF_W = 2;
    // Fetch address fields for the 2-way array.
    localparam int WAY_TAG_HI = 23;
    localparam int WAY_TAG_LO = 13;
    localparam int WAY_TAG_W = 11;
    localparam int WAY_IDX_HI = 12;
    localparam int WAY_IDX_W = 9;
    // Fetch address fields for a RAM set.
    localparam int RS_TAG_LO = 12;
    localparam int RS_TAG_W = 12;
    localparam int RS_IDX_HI = 11;
    localparam int RS_IDX_W = 8;
    // Fields common to both structures; bits 1 to 0 are never looked at.
    localparam int IDX_LO = 4;
    localparam int OFF_HI = 3;
    localparam int OFF_LO = 2;
    // Last values of the beat, flush and preload counters.
    localparam logic [OFF_W-1:0] LAST_BEAT = 2'h3;
    localparam logic [WAY_IDX_W-1:0] LAST_SET = 9'h1ff;
    localparam logic [RS_IDX_W-1:0] LAST_LINE = 8'hff;
    // Core status word three: cache control bit positions and reset value.
    localparam int ST_W = 16;
    localparam int ST_FRZ_BIT = 15;
    localparam int ST_EN_BIT = 14;
    localparam int ST_FLUSH_BIT = 13;
    localparam int ST_RO_BIT = 3;
    localparam logic [ST_W-1:0] ST_RESET = 16'h1c00;
    // Delay from the enable bit to the enabled flag.
    localparam int CLK_PERIOD_NS = 20;
    localparam int ENABLE_DELAY_NS = 80;
    localparam int ENABLE_DELAY_CYC = (ENABLE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] ENABLE_CNT = 4'(ENABLE_DELAY_CYC);

    // Controller states.
    typedef enum logic [2:0] {
        S_IDLE,
        S_LOOK,
        S_MREQ,
        S_MDATA,
        S_FIN,
        S_FLUSH
    } dicl_state_t;

    // What a running external transfer feeds.
    typedef enum logic [1:0] {
        K_WAY,
        K_RS,
        K_DROP,
        K_BYP
    } dicl_kind_t;

    // Request toward the external memory port.
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic burst;
    } dicl_mreq_t;
endpackage

// file: dicl_mem.sv
// Purpose: Single-port storage array with a registered read port.
// Assumes: One access per cycle; a write cycle returns no read data.
// Notes: No reset, the contents are qualified by valid bits elsewhere.
module dicl_mem #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 1024
) (
    input wire logic core_clk,
    input wire logic we,
    input wire logic [$clog2(DEPTH)-1:0] addr,
    input wire logic [WIDTH-1:0] wdata,
    output logic [WIDTH-1:0] rdata
);
    // The array itself.
    logic [WIDTH-1:0] mem [DEPTH];

    // Write or read, with the read word held in a register.
    always_ff @(posedge core_clk) begin
        if (we) begin
            mem[addr] <= wdata;
        end else begin
            rdata <= mem[addr];
        end
    end
endmodule

// file: dicl_hit_check.sv
// Purpose: Tag compare and hit decision for a group of cache structures.
// Assumes: Tags and valid bits are already read for the indexed line.
// Notes: Purely combinational.
module dicl_hit_check #(
    parameter int N = 2,
    parameter int TW = 11
) (
    input wire logic [N-1:0][TW-1:0] tags,
    input wire logic [TW-1:0] want,
    input wire logic [N-1:0] tag_ok,
    input wire logic [N-1:0] line_ok,
    output logic [N-1:0] match,
    output logic [N-1:0] hit
);
    // A hit needs both a matching tag and a valid line.
    for (genvar i = 0; i < N; i++) begin : g_cmp
        assign match[i] = tag_ok[i] && (tags[i] == want);
        assign hit[i] = match[i] && line_ok[i];
    end
endmodule

// file: dicl_mem_model.sv
// Purpose: Behavioural external memory port facing the cache fill side.
// Assumes: Each word read back carries 8'h5a in its top byte, above its own byte address.
// Notes: Ready waits one cycle; in every cycle that sends no beat the data line toggles.
module dicl_mem_model
    import dicl_pkg::*;
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic mem_req_valid,
    input wire dicl_mreq_t mem_req,
    output logic mem_req_ready,
    output logic mem_rvalid,
    output logic [DATA_W-1:0] mem_rdata,
    output int req_count
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [ADDR_W-1:0] a_q; // Address of the next beat.
    logic [2:0] left_q; // Beats still owed.
    // Accept, then stream words upward from the aligned start.
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            mem_req_ready <= 1'b0;
            mem_rvalid <= 1'b0;
            mem_rdata <= '0;
            a_q <= '0;
            left_q <= 3'h0;
            req_count <= 0;
        end else begin
            mem_req_ready <= 1'b0;
            mem_rvalid <= 1'b0;
            mem_rdata <= ~mem_rdata; // Stale data must not look valid.
            if (mem_req_valid && mem_req_ready) begin
                a_q <= mem_req.addr;
                left_q <= mem_req.burst ? 3'h4 : 3'h1;
                req_count <= req_count + 1;
            end else if (left_q != 3'h0) begin
                mem_rvalid <= 1'b1;
                mem_rdata <= {8'h5a, a_q};
                a_q <= a_q + 24'h000004;
                left_q <= left_q - 3'h1;
            end else if (mem_req_valid) begin
                mem_req_ready <= 1'b1;
            end
        end
    end
endmodule

// file: tb_dicl_cache.sv
// Purpose: Self-checking bench for the instruction cache lookup block.
// Assumes: Inputs change on the falling edge; RAM-set tag writes come from the bench.
// Notes: Expected words follow the memory model's address pattern.
module tb_dicl_cache;
    timeunit 1ns;
    timeprecision 100ps;
    import dicl_pkg::*;
    logic core_clk, sys_rst, fetch_req, fetch_ready, fetch_rvalid, st_wr, cache_enabled;
    logic mem_req_valid, mem_req_ready, mem_rvalid;
    logic [ADDR_W-1:0] fetch_addr;
    logic [DATA_W-1:0] fetch_rdata, mem_rdata;
    logic [ST_W-1:0] st_wdata, st_rdata;
    logic [NUM_RS-1:0] rs_tag_valid, rs_tag_wr;
    logic [RS_TAG_W-1:0] rs_tag_wdata;
    dicl_mreq_t mem_req;
    int req_count, err_count, checks, k;
    int cyc = 0;
    dicl_cache u_dicl_cache (.core_clk(core_clk), .sys_rst(sys_rst), .fetch_req(fetch_req),
        .fetch_addr(fetch_addr), .fetch_ready(fetch_ready), .fetch_rvalid(fetch_rvalid),
        .fetch_rdata(fetch_rdata), .st_wr(st_wr), .st_wdata(st_wdata), .st_rdata(st_rdata),
        .cache_enabled(cache_enabled), .rs_tag_wr(rs_tag_wr), .rs_tag_wdata(rs_tag_wdata),
        .rs_tag_valid(rs_tag_valid), .mem_req_valid(mem_req_valid), .mem_req(mem_req),
        .mem_req_ready(mem_req_ready), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata));
    dicl_mem_model u_dicl_mem_model (.core_clk(core_clk), .sys_rst(sys_rst),
        .mem_req_valid(mem_req_valid), .mem_req(mem_req), .mem_req_ready(mem_req_ready),
        .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata), .req_count(req_count));
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic st_write(input logic [ST_W-1:0] v);
        @(negedge core_clk);
        st_wr = 1'b1;
        st_wdata = v;
        @(negedge core_clk);
        st_wr = 1'b0;
    endtask
    // One fetch; the request holds until a rising edge sees fetch_ready.
    task automatic fetch(input logic [ADDR_W-1:0] a, input int bursts);
        int n0;
        n0 = req_count;
        @(negedge core_clk);
        fetch_req = 1'b1;
        fetch_addr = a;
        for (k = 0; k < 900 && fetch_ready !== 1'b1; k++) begin
            @(negedge core_clk);
        end
        @(negedge core_clk);
        fetch_req = 1'b0;
        for (k = 0; k < 900 && fetch_rvalid !== 1'b1; k++) begin
            @(negedge core_clk);
        end
        // Without this a lost answer would pass on the previous word.
        chk("fetch_rvalid", 32'h1, 32'(fetch_rvalid));
        chk("fetch_rdata", {8'h5a, a[23:2], 2'b00}, fetch_rdata);
        chk("mem requests", 32'(n0 + bursts), 32'(req_count));
    endtask
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    // Hang guard: the whole sequence needs about 2,700 cycles.
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            tally_and_finish;
        end
    end
    initial begin
        sys_rst = 1'b1;
        fetch_req = 1'b0;
        fetch_addr = '0;
        st_wr = 1'b0;
        st_wdata = '0;
        rs_tag_wr = '0;
        rs_tag_wdata = '0;
        repeat (20) @(negedge core_clk);
        sys_rst = 1'b0;
        chk("st_rdata", 32'h1c00, 32'(st_rdata));
        chk("rs_tag_valid", 32'h0, 32'(rs_tag_valid));
        fetch(24'h001236, 1);
        $display("test reset and bypass done");
        st_write(16'h5c00);
        repeat (5) @(negedge core_clk);
        chk("cache_enabled", 32'h1, 32'(cache_enabled));
        fetch(24'h012348, 1);
        fetch(24'h01234b, 0);
        fetch(24'h012340, 0);
        fetch(24'h01234c, 0);
        $display("test miss and hit done");
        st_write(16'h7c00);
        @(negedge core_clk);
        chk("flush bit", 32'h1, 32'(st_rdata[ST_FLUSH_BIT]));
        for (k = 0; k < 900 && st_rdata[ST_FLUSH_BIT] !== 1'b0; k++) begin
            @(negedge core_clk);
        end
        chk("flush bit", 32'h0, 32'(st_rdata[ST_FLUSH_BIT]));
        fetch(24'h012340, 1);
        $display("test flush done");
        st_write(16'hdc00);
        fetch(24'h012344, 0);
        fetch(24'h020000, 1);
        fetch(24'h020004, 1);
        $display("test freeze done");
        st_write(16'h5c00);
        @(negedge core_clk);
        rs_tag_wdata = 12'h030;
        rs_tag_wr = 2'h1;
        @(negedge core_clk);
        rs_tag_wr = 2'h0;
        for (k = 0; k < 3000 && rs_tag_valid !== 2'h1; k++) begin
            @(negedge core_clk);
        end
        chk("rs_tag_valid", 32'h1, 32'(rs_tag_valid));
        fetch(24'h030128, 0);
        $display("test RAM set done");
        tally_and_finish;
    end
endmodule
